// ==== verilog/ddr_capture_defs.svh ====
// Purpose: Shared constants for the strobe-group DDR capture datapath
// Assumes: Core clock of 125 MHz, one strobe group per byte lane
// Notes:   Times are kept in their own unit; cycle counts derive from them
//
// Behaviour
// - The datapath serves both DDR SDRAM and FCRAM at up to 133 MHz; here writes use a fixed 32 ns half-period on the 125 MHz core clock.
// - A strobe group is one strobe, eight data lines and one mask line.
// - A strobe times capture only for the eight data lines of its group.
// - At most eight strobe groups exist in the byte-wide bus mode.
// - The strobe is delayed 90 degrees for DDR or 72 for FCRAM.
// - The delayed strobe acts as the timing reference for core capture.
// - Read data is captured by the delayed strobe of its own group.
// - Write data and output enables are timed by a shifted clock phase.
// - Captured read data is passed through registers into the core.
`ifndef DDR_CAPTURE_DEFS_SVH
`define DDR_CAPTURE_DEFS_SVH

`define DSC_GROUPS        8
`define DSC_DQ_W          8
`define DSC_CNT_W         8
`define DSC_DDR_DEG       90
`define DSC_FCRAM_DEG     72
`define DSC_FULL_DEG      360
`define DSC_CLK_MHZ       125
`define DSC_MAX_MEM_MHZ   133
`define DSC_WR_HALF_NS    32
`define DSC_WR_HALF_CYC   ((`DSC_WR_HALF_NS * `DSC_CLK_MHZ + 999) / 1000)
`define DSC_CNT_MAX       8'hff

`endif

// ==== verilog/ddr_capture_pkg.sv ====
// Purpose: Types for the strobe-group DDR capture datapath
// Assumes: Constants live in ddr_capture_defs.svh
// Notes:   Nothing is imported; users write ddr_capture_pkg::name
package ddr_capture_pkg;

    typedef enum logic {
        MEM_DDR,
        MEM_FCRAM
    } mem_kind_t;

    typedef enum logic [1:0] {
        WR_IDLE,
        WR_RISE,
        WR_FALL
    } wr_state_t;

endpackage : ddr_capture_pkg

// ==== verilog/strobe_group.sv ====
// Purpose: Read capture for one strobe group (one strobe, eight data lines)
// Assumes: Strobe and data arrive asynchronously to the core clock
// Notes:   The strobe period is measured so the phase delay tracks it
`timescale 1ns/1ps
`default_nettype none
`include "ddr_capture_defs.svh"

module strobe_group (
    input  wire logic                       clock,
    input  wire logic                       nrst,
    input  wire ddr_capture_pkg::mem_kind_t mem_kind,
    input  wire logic                       strobe_in,
    input  wire logic [`DSC_DQ_W-1:0]       dq_in,
    output logic      [2*`DSC_DQ_W-1:0]     word,
    output logic                            word_valid
);
    logic                   stb_s1_r;
    logic                   stb_s2_r;
    logic                   stb_s3_r;
    logic [`DSC_DQ_W-1:0]   dq_s1_r;
    logic [`DSC_DQ_W-1:0]   dq_s2_r;
    logic [`DSC_CNT_W-1:0]  since_r;
    logic [`DSC_CNT_W-1:0]  half_r;
    logic [`DSC_CNT_W-1:0]  dly_r;
    logic                   pend_r;
    logic                   pend_rise_r;
    logic [`DSC_DQ_W-1:0]   rise_byte_r;

    // Only this group's strobe is examined here
    wire edge_seen = stb_s2_r ^ stb_s3_r;
    wire rising    = stb_s2_r & ~stb_s3_r;
    // A quarter period is half a half-period; FCRAM wants a fifth period
    wire [`DSC_CNT_W+1:0] half_x2 = {1'b0, half_r, 1'b0};
    wire [`DSC_CNT_W-1:0] dly_ddr = half_r >> 1;
    wire [`DSC_CNT_W-1:0] dly_fc  =
        `DSC_CNT_W'(half_x2 * `DSC_FCRAM_DEG / `DSC_FULL_DEG);
    wire [`DSC_CNT_W-1:0] dly_sel =
        (mem_kind == ddr_capture_pkg::MEM_FCRAM) ? dly_fc : dly_ddr;
    // Never less than one cycle, so an edge is never sampled on itself
    wire [`DSC_CNT_W-1:0] dly_use =
        (dly_sel == '0) ? `DSC_CNT_W'(1) : dly_sel;
    wire fire = pend_r & (dly_r <= `DSC_CNT_W'(1));

    always_ff @(posedge clock) begin
        stb_s1_r <= strobe_in;
        stb_s2_r <= stb_s1_r;
        stb_s3_r <= stb_s2_r;
        dq_s1_r  <= dq_in;
        dq_s2_r  <= dq_s1_r;
    end

    // Period tracking: saturating count between edges
    always_ff @(posedge clock) begin
        if (!nrst) begin
            since_r <= '0;
            half_r  <= `DSC_CNT_W'(2);
        end else if (edge_seen) begin
            since_r <= `DSC_CNT_W'(1);
            half_r  <= since_r;
        end else if (since_r != `DSC_CNT_MAX) begin
            since_r <= since_r + `DSC_CNT_W'(1);
        end
    end

    // Each edge arms a delayed sample point
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pend_r      <= 1'b0;
            pend_rise_r <= 1'b0;
            dly_r       <= '0;
        end else if (edge_seen) begin
            pend_r      <= 1'b1;
            pend_rise_r <= rising;
            dly_r       <= dly_use;
        end else if (fire) begin
            pend_r      <= 1'b0;
        end else if (pend_r) begin
            dly_r       <= dly_r - `DSC_CNT_W'(1);
        end
    end

    // Rise byte then fall byte form one word per strobe cycle
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rise_byte_r <= '0;
            word        <= '0;
            word_valid  <= 1'b0;
        end else begin
            word_valid <= fire & ~pend_rise_r;
            if (fire & pend_rise_r)
                rise_byte_r <= dq_s2_r;
            if (fire & ~pend_rise_r)
                word <= {rise_byte_r, dq_s2_r};
        end
    end
endmodule : strobe_group
`default_nettype wire

// ==== verilog/ddr_strobe_capture_path.sv ====
// Purpose: DDR SDRAM / FCRAM byte-lane datapath, read capture and write out
// Assumes: Memory clock at most 133 MHz; core clock 125 MHz
// Notes:   The shifted write phase is an enable pulse from a divider
`timescale 1ns/1ps
`default_nettype none
`include "ddr_capture_defs.svh"

module ddr_strobe_capture_path (
    input  wire logic                               clock,
    input  wire logic                               nrst,
    input  wire ddr_capture_pkg::mem_kind_t         mem_kind,
    input  wire logic [`DSC_GROUPS-1:0]             strobe_in,
    input  wire logic [`DSC_GROUPS*`DSC_DQ_W-1:0]   dq_in,
    output logic      [`DSC_GROUPS*`DSC_DQ_W-1:0]   dq_out,
    output logic      [`DSC_GROUPS*`DSC_DQ_W-1:0]   dq_oe,
    output logic      [`DSC_GROUPS-1:0]             strobe_out,
    output logic      [`DSC_GROUPS-1:0]             strobe_oe,
    output logic      [`DSC_GROUPS-1:0]             mask_out,
    output logic      [2*`DSC_GROUPS*`DSC_DQ_W-1:0] rd_data,
    output logic      [`DSC_GROUPS-1:0]             rd_valid,
    input  wire logic                               wr_valid,
    input  wire logic [2*`DSC_GROUPS*`DSC_DQ_W-1:0] wr_data,
    input  wire logic [2*`DSC_GROUPS-1:0]           wr_mask,
    output logic                                    wr_ready
);
    localparam int GW = 2 * `DSC_DQ_W;
    localparam int HALF_CYC = (`DSC_WR_HALF_CYC < 1) ? 1 : `DSC_WR_HALF_CYC;

    logic [GW*`DSC_GROUPS-1:0]   cap_word;
    logic [`DSC_GROUPS-1:0]      cap_valid;
    logic [GW*`DSC_GROUPS-1:0]   wr_hold_r;
    logic [2*`DSC_GROUPS-1:0]    mask_hold_r;
    logic [7:0]                  div_r;
    logic                        phase_en_r;
    ddr_capture_pkg::wr_state_t  wr_st_r;
    ddr_capture_pkg::wr_state_t  wr_st_nxt;

    // One capture unit per byte lane, eight at most
    genvar g;
    generate
        for (g = 0; g < `DSC_GROUPS; g = g + 1) begin : lane
            strobe_group u_grp (
                .clock      (clock),
                .nrst       (nrst),
                .mem_kind   (mem_kind),
                .strobe_in  (strobe_in[g]),
                .dq_in      (dq_in[g*`DSC_DQ_W +: `DSC_DQ_W]),
                .word       (cap_word[g*GW +: GW]),
                .word_valid (cap_valid[g])
            );
        end
    endgenerate

    // Extra register stage moves captures fully into core timing
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rd_data  <= '0;
            rd_valid <= '0;
        end else begin
            rd_valid <= cap_valid;
            for (int i = 0; i < `DSC_GROUPS; i++) begin
                if (cap_valid[i])
                    rd_data[i*GW +: GW] <= cap_word[i*GW +: GW];
            end
        end
    end

    // Shifted write phase: a half-period of a memory clock at or below
    // the 133 MHz limit, as enable pulses on the core clock
    always_ff @(posedge clock) begin
        if (!nrst) begin
            div_r      <= '0;
            phase_en_r <= 1'b0;
        end else if (div_r == 8'(HALF_CYC - 1)) begin
            div_r      <= '0;
            phase_en_r <= 1'b1;
        end else begin
            div_r      <= div_r + 8'h01;
            phase_en_r <= 1'b0;
        end
    end

    wire take_word = phase_en_r & (wr_st_r != ddr_capture_pkg::WR_RISE)
                     & wr_valid;

    always_comb begin
        wr_st_nxt = wr_st_r;
        if (phase_en_r) begin
            unique case (wr_st_r)
                ddr_capture_pkg::WR_IDLE:
                    wr_st_nxt = wr_valid ? ddr_capture_pkg::WR_RISE
                                         : ddr_capture_pkg::WR_IDLE;
                ddr_capture_pkg::WR_RISE:
                    wr_st_nxt = ddr_capture_pkg::WR_FALL;
                ddr_capture_pkg::WR_FALL:
                    wr_st_nxt = wr_valid ? ddr_capture_pkg::WR_RISE
                                         : ddr_capture_pkg::WR_IDLE;
                default:
                    wr_st_nxt = ddr_capture_pkg::WR_IDLE;
            endcase
        end
    end

    // Per-lane rise/fall byte selection for the pins
    logic [`DSC_GROUPS*`DSC_DQ_W-1:0] rise_bytes;
    logic [`DSC_GROUPS*`DSC_DQ_W-1:0] fall_bytes;
    logic [`DSC_GROUPS-1:0]           rise_mask;
    logic [`DSC_GROUPS-1:0]           fall_mask;
    generate
        for (g = 0; g < `DSC_GROUPS; g = g + 1) begin : sel
            assign rise_bytes[g*`DSC_DQ_W +: `DSC_DQ_W] =
                wr_data[g*GW + `DSC_DQ_W +: `DSC_DQ_W];
            assign fall_bytes[g*`DSC_DQ_W +: `DSC_DQ_W] =
                wr_hold_r[g*GW +: `DSC_DQ_W];
            assign rise_mask[g] = wr_mask[2*g+1];
            assign fall_mask[g] = mask_hold_r[2*g];
        end
    endgenerate

    // Pins change only on the shifted phase, never on the read strobe
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wr_st_r     <= ddr_capture_pkg::WR_IDLE;
            wr_hold_r   <= '0;
            mask_hold_r <= '0;
            dq_out      <= '0;
            dq_oe       <= '0;
            strobe_out  <= '0;
            strobe_oe   <= '0;
            mask_out    <= '0;
            wr_ready    <= 1'b0;
        end else begin
            wr_st_r  <= wr_st_nxt;
            wr_ready <= take_word;
            if (take_word) begin
                wr_hold_r   <= wr_data;
                mask_hold_r <= wr_mask;
                dq_out      <= rise_bytes;
                mask_out    <= rise_mask;
                strobe_out  <= '1;
                dq_oe       <= '1;
                strobe_oe   <= '1;
            end else if (phase_en_r &&
                         wr_st_r == ddr_capture_pkg::WR_RISE) begin
                dq_out      <= fall_bytes;
                mask_out    <= fall_mask;
                strobe_out  <= '0;
            end else if (phase_en_r) begin
                // Bus released so the memory can drive reads
                dq_oe       <= '0;
                strobe_oe   <= '0;
                strobe_out  <= '0;
            end
        end
    end
endmodule : ddr_strobe_capture_path
`default_nettype wire

// ==== dv/capture_sva.sv ====
// Purpose: Port checks of the strobe capture datapath
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to the top module by name
`timescale 1ns/1ps
`default_nettype none
module capture_sva (
    input wire logic         clock,
    input wire logic         nrst,
    input wire logic [7:0]   strobe_in,
    input wire logic [7:0]   strobe_out,
    input wire logic [7:0]   strobe_oe,
    input wire logic [7:0]   rd_valid,
    input wire logic [63:0]  dq_out,
    input wire logic [63:0]  dq_oe,
    input wire logic [127:0] rd_data,
    input wire logic         wr_valid,
    input wire logic         wr_ready
);
    logic [7:0] idle_r;
    logic [7:0] seen_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence rise_s; strobe_out == 8'hff && strobe_oe == 8'hff; endsequence
    sequence fall_s; strobe_out == 8'h00 && strobe_oe == 8'hff; endsequence
    // Reads drain within a few cycles of the last edge; 40 leaves margin
    always_ff @(posedge clock) begin
        seen_r <= strobe_in;
        if (!nrst || strobe_in != seen_r) idle_r <= 8'h00;
        else if (idle_r != 8'hff) idle_r <= idle_r + 8'h01;
    end
    ready_gap_a:
        assert property (wr_ready |=> !wr_ready [*7])
        else $error("write words too close");
    taken_valid_a:
        assert property (wr_ready |-> $past(wr_valid))
        else $error("write taken without valid");
    wr_phase_a:
        assert property (wr_ready |-> rise_s [*4] ##1 fall_s [*4])
        else $error("write strobe phases wrong");
    rise_hold_a:
        assert property (wr_ready |=> $stable(dq_out) [*3])
        else $error("rise data not held");
    oe_match_a:
        assert property (dq_oe == {64{strobe_oe[0]}}
                         && strobe_oe == {8{strobe_oe[0]}})
        else $error("enables disagree");
    oe_start_a:
        assert property ($rose(strobe_oe[0]) |-> wr_ready)
        else $error("enable rose without a word");
    valid_pulse_a:
        assert property ((rd_valid & $past(rd_valid)) == 8'h00)
        else $error("rd_valid longer than one cycle");
    data_hold_a:
        assert property (rd_data != $past(rd_data) |-> rd_valid != 8'h00)
        else $error("rd_data changed without rd_valid");
    idle_quiet_a:
        assert property (idle_r > 8'd40 |-> rd_valid == 8'h00)
        else $error("read word without strobe");
endmodule : capture_sva
bind ddr_strobe_capture_path capture_sva capture_sva_i (.*);
`default_nettype wire

// ==== dv/mem_model.sv ====
// Purpose: Memory side, returns read bursts on strobe and data lines
// Assumes: 64 ns strobe, data launched edge-aligned with the strobe
// Notes:   Idle strobe stands still; released data shows inverted bits
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    output logic [7:0]  strobe_in,
    output logic [63:0] dq_in
);
    initial begin
        strobe_in = 8'h00;
        dq_in = 64'h0;
    end
    // Word 0 is a preamble so the design can measure the strobe period
    task automatic burst(input logic [7:0] lanes,
                         input logic [127:0] wds [5]);
        for (int k = 0; k < 5; k++) begin
            for (int h = 1; h >= 0; h--) begin
                for (int g = 0; g < 8; g++)
                    dq_in[8*g +: 8] = wds[k][16*g+8*h +: 8];
                strobe_in = (h == 1) ? lanes : 8'h00;
                #32;
            end
        end
        dq_in = ~dq_in;
    endtask : burst
endmodule : mem_model
`default_nettype wire

// ==== dv/ddr_strobe_capture_path_test.sv ====
// Purpose: Self-checking bench for the strobe capture datapath
// Assumes: 125 MHz core clock, 64 ns strobe
// Notes:   The preamble word of a burst may or may not be delivered
`timescale 1ns/1ps
`default_nettype none
module ddr_strobe_capture_path_test;
    logic                       clock = 1'b0;
    logic                       nrst = 1'b0;
    ddr_capture_pkg::mem_kind_t mem_kind = ddr_capture_pkg::MEM_DDR;
    logic                       wr_valid = 1'b0;
    logic [127:0]               wr_data = 128'h0;
    logic [15:0]                wr_mask = 16'h0;
    logic                       wr_ready;
    logic [7:0]                 strobe_in, strobe_out, strobe_oe;
    logic [7:0]                 mask_out, rd_valid;
    logic [63:0]                dq_in, dq_out, dq_oe;
    logic [127:0]               rd_data;
    logic [15:0]                got [8][$];
    int                         n_errors = 0;
    int                         num_checks = 0;
    int                         seed = 26;
    always #4 clock = ~clock;
    mem_model mem_model_i (.*);
    ddr_strobe_capture_path ddr_strobe_capture_path_i (.*);
    always @(posedge clock)
        for (int g = 0; g < 8; g++)
            if (rd_valid[g] === 1'b1) got[g].push_back(rd_data[16*g +: 16]);
    function automatic logic [87:0] pins();
        return {dq_out, mask_out, strobe_out, strobe_oe};
    endfunction : pins
    task automatic check_v(string what, logic [127:0] exp, logic [127:0] seen);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : check_v
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    task automatic rd_test(ddr_capture_pkg::mem_kind_t k, logic [7:0] lanes);
        logic [127:0] wds [5];
        int           n;
        mem_kind = k;
        foreach (wds[i])
            wds[i] = {$random(seed), $random(seed), $random(seed), $random(seed)};
        foreach (got[g]) got[g].delete();
        mem_model_i.burst(lanes, wds);
        repeat (40) @(posedge clock);
        #1;
        for (int g = 0; g < 8; g++) begin
            n = lanes[g] ? 4 : 0;
            if (got[g].size() > n) void'(got[g].pop_front());
            check_v("word count", n, got[g].size());
            for (int j = 0; j < got[g].size() && j < n; j++)
                check_v("read word", wds[j+1][16*g +: 16], got[g][j]);
        end
        $display("read test lanes %h kind %0d done", lanes, k);
    endtask : rd_test
    task automatic wr_word(logic [127:0] d, logic [15:0] m);
        logic [63:0] rb, fb;
        logic [7:0]  rm, fm;
        int          n;
        for (int g = 0; g < 8; g++) begin
            rb[8*g +: 8] = d[16*g+8 +: 8];
            fb[8*g +: 8] = d[16*g +: 8];
            rm[g] = m[2*g+1];
            fm[g] = m[2*g];
        end
        wr_valid = 1'b1;
        wr_data = d;
        wr_mask = m;
        for (n = 0; n < 20 && wr_ready !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        check_v("rise pins", {rb, rm, 16'hffff}, pins());
        check_v("enables", {1'b1, {64{1'b1}}}, {wr_ready, dq_oe});
        repeat (4) @(posedge clock);
        #1;
        check_v("fall pins", {fb, fm, 16'h00ff}, pins());
    endtask : wr_word
    initial begin
        #20000;
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clock);
        #1;
        nrst = 1'b1;
        check_v("reset state", 80'h0, {strobe_oe, rd_valid, dq_oe});
        rd_test(ddr_capture_pkg::MEM_DDR, 8'hff);
        rd_test(ddr_capture_pkg::MEM_FCRAM, 8'hff);
        rd_test(ddr_capture_pkg::MEM_DDR, 8'h5a);
        for (int i = 0; i < 3; i++)
            wr_word({$random(seed), $random(seed), $random(seed),
                     $random(seed)}, 16'($random(seed)));
        wr_valid = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        check_v("idle enables", 72'h0, {dq_oe, strobe_oe});
        $display("write test done");
        finish_test();
    end
endmodule : ddr_strobe_capture_path_test
`default_nettype wire
